//--- core/gpfs_pkg.sv
/*
  Shared constants and types of the general pin function select block:
  register offsets, pin settings layout, designation codes, the reset
  command signature and the response byte positions.
  Assumes a 32-bit APB master and four general pins.
*/
package gpfs_pkg;

  localparam int unsigned GPFS_NUM_PINS = 4;

  // APB byte offsets
  localparam logic [7:0] GPFS_OFS_PIN0 = 8'h00;
  localparam logic [7:0] GPFS_OFS_PIN1 = 8'h04;
  localparam logic [7:0] GPFS_OFS_PIN2 = 8'h08;
  localparam logic [7:0] GPFS_OFS_PIN3 = 8'h0c;
  localparam logic [7:0] GPFS_OFS_PWD_LO = 8'h10;
  localparam logic [7:0] GPFS_OFS_PWD_HI = 8'h14;
  localparam logic [7:0] GPFS_OFS_EDGE = 8'h18;
  localparam logic [7:0] GPFS_OFS_STATUS = 8'h1c;
  localparam logic [7:0] GPFS_OFS_MASK = 8'h20;
  localparam logic [7:0] GPFS_OFS_PIN_IN = 8'h24;
  localparam logic [7:0] GPFS_OFS_RESP_IDX = 8'h28;
  localparam logic [7:0] GPFS_OFS_RESP_DATA = 8'h2c;
  localparam logic [7:0] GPFS_OFS_CMD_BYTE = 8'h30;
  localparam logic [7:0] GPFS_OFS_CMD_GO = 8'h34;

  // Reset values
  localparam logic [7:0] GPFS_RST_PIN = 8'h08;
  localparam logic [31:0] GPFS_RST_PWD = 32'h0000_0000;
  localparam logic [7:0] GPFS_RST_EDGE = 8'h00;
  localparam logic [1:0] GPFS_RST_STATUS = 2'h0;
  localparam logic [1:0] GPFS_RST_MASK = 2'h0;

  // Field positions
  localparam int unsigned GPFS_BIT_OUT_VAL = 4;
  localparam int unsigned GPFS_BIT_DIR_IN = 3;
  localparam int unsigned GPFS_BIT_EDGE_NEG = 6;
  localparam int unsigned GPFS_BIT_EDGE_POS = 5;
  localparam int unsigned GPFS_STS_EDGE = 0;
  localparam int unsigned GPFS_STS_RESP = 1;
  localparam int unsigned GPFS_CMD_IDX_LSB = 8;

  // Designation codes
  localparam logic [2:0] GPFS_DES_GPIO = 3'h0;
  localparam logic [2:0] GPFS_DES_IRQ = 3'h4;

  // Per pin: which function codes 001..100 drive the pin or hand it to analog
  localparam logic [3:0] GPFS_FN_OUT [GPFS_NUM_PINS] = '{4'h3, 4'h5, 4'h1, 4'h1};
  localparam logic [3:0] GPFS_FN_ANA [GPFS_NUM_PINS] = '{4'h0, 4'h2, 4'h6, 4'h6};

  // Reset chip command signature
  localparam logic [7:0] GPFS_CMD_RESET [4] = '{8'h70, 8'hab, 8'hcd, 8'hef};
  localparam logic [5:0] GPFS_CMD_HDR_LEN = 6'h04;

  // Response byte positions
  localparam logic [5:0] GPFS_RB_PWD_FIRST = 6'h0e;
  localparam logic [5:0] GPFS_RB_PWD_LAST = 6'h15;
  localparam logic [5:0] GPFS_RB_PIN_FIRST = 6'h16;
  localparam logic [5:0] GPFS_RB_PIN_LAST = 6'h19;

  typedef struct packed {
    logic [2:0] spare;
    logic out_val;
    logic dir_in;
    logic [2:0] desig;
  } gpfs_pin_cfg_t;

  typedef struct packed {
    logic out;
    logic oe_n;
  } gpfs_pad_t;

endpackage

//--- core/gpfs_pin_cell.sv
/*
  One general pin: chooses between GPIO and the function that the
  designation code selects, and registers the pad drive.
  Assumes function drive values arrive synchronous to pclk.
*/
module gpfs_pin_cell
  import gpfs_pkg::*;
#(
  parameter logic [3:0] FN_OUT = 4'h0,
  parameter logic [3:0] FN_ANA = 4'h0
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire gpfs_pin_cfg_t cfg, // Pin settings byte
  input wire logic [3:0] fn_drv, // Values for codes 001..100
  output gpfs_pad_t pad, // Registered pad drive
  output logic analog_en // Pin handed to analog
);

  logic is_gpio;
  logic fn_valid;
  logic [1:0] fn_idx;
  logic fn_out;
  gpfs_pad_t pad_d;
  gpfs_pad_t pad_q;
  logic ana_q;

  // Decode designation; codes above 100 are don't care and leave the pin idle
  assign is_gpio = (cfg.desig == GPFS_DES_GPIO);
  assign fn_valid = (cfg.desig != GPFS_DES_GPIO) && (cfg.desig <= GPFS_DES_IRQ);
  assign fn_idx = 2'(cfg.desig - 3'h1);
  assign fn_out = fn_valid && FN_OUT[fn_idx];

  // Direction and value bits only count in GPIO mode
  always_comb begin
    pad_d = '{out: 1'b0, oe_n: 1'b1};
    if (is_gpio) begin
      pad_d.oe_n = cfg.dir_in;
      pad_d.out = cfg.dir_in ? 1'b0 : cfg.out_val;
    end else if (fn_out) begin
      pad_d.oe_n = 1'b0;
      pad_d.out = fn_drv[fn_idx];
    end
  end

  // Registered so the pad never glitches on a settings change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_q <= '{out: 1'b0, oe_n: 1'b1};
      ana_q <= 1'b0;
    end else begin
      pad_q <= pad_d;
      ana_q <= fn_valid && FN_ANA[fn_idx];
    end
  end

  assign pad = pad_q;
  assign analog_en = ana_q;

endmodule

//--- core/gpfs_top.sv
/*
  General pin function select: four pin settings bytes, password bytes,
  response byte readout, reset chip command decode and interrupt edge
  detection on pin one, all behind an APB slave.
  Assumes pad inputs already synchronous to pclk; the system resets the
  whole chip (bus detach included) while chip_reset_req is high.
*/
// Decided for this implementation: the register addresses and the APB register port.
// What this block does
// - Password bytes four-eight at response 17-21
// - GPIO output drives the settings value bit
// - Direction bit: one input, GPIO only
// - Low three bits designate; 000 is GPIO
// - Pin zero: suspend, receive LED functions
// - Pin one: clock, analog, transmit, interrupt
// - Pin two: enumeration done, analog, DAC
// - Pin three: bus LED, analog, DAC
// - Reset command fully resets, drops off bus
// - Reset gets no response; others do
// - Reset signature 70 ab cd ef, zeros
// - Interrupt flag on enabled edge polarity
module gpfs_top
  import gpfs_pkg::*;
(
  input wire logic pclk, // APB clock, 25 MHz
  input wire logic presetn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [3:0] pad_in, // Pin input levels
  output logic [3:0] pad_out, // Pin output values
  output logic [3:0] pad_oe_n, // Pin drive enable, low
  output logic [3:0] pin_analog, // Pin handed to analog
  input wire logic suspend_indicator, // Suspend state
  input wire logic serial_receive_indicator, // Receive activity
  input wire logic serial_transmit_indicator, // Transmit activity
  input wire logic clock_reference, // Clock reference out
  input wire logic enumeration_done_indicator, // Enumeration done
  input wire logic bus_activity_indicator, // Bus activity
  output logic resp_ready, // Command answered pulse
  output logic chip_reset_req, // Chip reset request pulse
  output logic irq // Level interrupt
);

  gpfs_pin_cfg_t pin_cfg_q [GPFS_NUM_PINS];
  logic [63:0] pwd_q;
  logic [7:0] edge_q;
  logic [1:0] sts_q;
  logic [1:0] mask_q;
  logic [5:0] resp_idx_q;
  logic [3:0] hdr_ok_q;
  logic tail_bad_q;
  logic pin1_prev_q;
  logic [31:0] prdata_q;
  logic resp_q;
  logic chip_rst_q;
  logic [3:0] fn_drv [GPFS_NUM_PINS];
  gpfs_pad_t pad [GPFS_NUM_PINS];

  // Response byte at a report position; unlisted bytes read zero
  function automatic logic [7:0] resp_byte(input logic [5:0] idx,
                                           input logic [63:0] pwd,
                                           input logic [31:0] pins);
    logic [5:0] off;
    off = 6'h00;
    resp_byte = 8'h00;
    if (idx >= GPFS_RB_PWD_FIRST && idx <= GPFS_RB_PWD_LAST) begin
      off = idx - GPFS_RB_PWD_FIRST;
      resp_byte = pwd[off[2:0]*8 +: 8];
    end else if (idx >= GPFS_RB_PIN_FIRST && idx <= GPFS_RB_PIN_LAST) begin
      off = idx - GPFS_RB_PIN_FIRST;
      resp_byte = pins[off[1:0]*8 +: 8];
    end
  endfunction

  // Pin settings byte of a pin; spare bits read back as stored zero
  function automatic logic [7:0] pin_byte(input gpfs_pin_cfg_t c);
    pin_byte = {3'h0, c.out_val, c.dir_in, c.desig};
  endfunction

  // APB phase decode
  logic setup_ph;
  logic wr_acc;
  logic hit_pin;
  logic [1:0] pin_sel;
  logic hit_known;
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign hit_pin = (paddr[7:4] == 4'h0) && (paddr[1:0] == 2'h0);
  assign pin_sel = paddr[3:2];
  assign hit_known = hit_pin || (paddr == GPFS_OFS_PWD_LO) || (paddr == GPFS_OFS_PWD_HI) ||
                     (paddr == GPFS_OFS_EDGE) || (paddr == GPFS_OFS_STATUS) ||
                     (paddr == GPFS_OFS_MASK) || (paddr == GPFS_OFS_PIN_IN) ||
                     (paddr == GPFS_OFS_RESP_IDX) || (paddr == GPFS_OFS_RESP_DATA) ||
                     (paddr == GPFS_OFS_CMD_BYTE) || (paddr == GPFS_OFS_CMD_GO);

  // Named write strobes
  logic wr_pwd_lo;
  logic wr_pwd_hi;
  logic wr_edge;
  logic wr_sts;
  logic wr_mask;
  logic wr_ridx;
  logic wr_cbyte;
  logic wr_go;
  assign wr_pwd_lo = wr_acc && (paddr == GPFS_OFS_PWD_LO);
  assign wr_pwd_hi = wr_acc && (paddr == GPFS_OFS_PWD_HI);
  assign wr_edge = wr_acc && (paddr == GPFS_OFS_EDGE);
  assign wr_sts = wr_acc && (paddr == GPFS_OFS_STATUS);
  assign wr_mask = wr_acc && (paddr == GPFS_OFS_MASK);
  assign wr_ridx = wr_acc && (paddr == GPFS_OFS_RESP_IDX);
  assign wr_cbyte = wr_acc && (paddr == GPFS_OFS_CMD_BYTE);
  assign wr_go = wr_acc && (paddr == GPFS_OFS_CMD_GO);

  // Command assembly: index in bits 13:8, byte in 7:0
  logic [5:0] cmd_idx;
  logic [7:0] cmd_val;
  logic cmd_is_reset;
  assign cmd_idx = pwdata[GPFS_CMD_IDX_LSB +: 6];
  assign cmd_val = pwdata[7:0];
  assign cmd_is_reset = (&hdr_ok_q) && !tail_bad_q;

  // Full self reset also returns the settings, password, edge, mask, index and status registers to their reset values
  logic self_rst;
  assign self_rst = wr_go && cmd_is_reset;

  // Header bytes must each be written with the signature; any nonzero tail spoils it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdr_ok_q <= 4'h0;
      tail_bad_q <= 1'b0;
    end else if (wr_go) begin
      hdr_ok_q <= 4'h0;
      tail_bad_q <= 1'b0;
    end else if (wr_cbyte) begin
      if (cmd_idx < GPFS_CMD_HDR_LEN) begin
        hdr_ok_q[cmd_idx[1:0]] <= (cmd_val == GPFS_CMD_RESET[cmd_idx[1:0]]);
      end else if (cmd_val != 8'h00) begin
        tail_bad_q <= 1'b1;
      end
    end
  end

  // Configuration registers; spare bits 7:5 dropped on write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < GPFS_NUM_PINS; i++) begin
        pin_cfg_q[i] <= gpfs_pin_cfg_t'(GPFS_RST_PIN);
      end
      pwd_q <= {GPFS_RST_PWD, GPFS_RST_PWD};
      edge_q <= GPFS_RST_EDGE;
      mask_q <= GPFS_RST_MASK;
      resp_idx_q <= 6'h00;
    end else if (self_rst) begin
      for (int i = 0; i < GPFS_NUM_PINS; i++) begin
        pin_cfg_q[i] <= gpfs_pin_cfg_t'(GPFS_RST_PIN);
      end
      pwd_q <= {GPFS_RST_PWD, GPFS_RST_PWD};
      edge_q <= GPFS_RST_EDGE;
      mask_q <= GPFS_RST_MASK;
      resp_idx_q <= 6'h00;
    end else begin
      if (wr_acc && hit_pin) begin
        pin_cfg_q[pin_sel] <= gpfs_pin_cfg_t'({3'h0, pwdata[4:0]});
      end
      if (wr_pwd_lo) begin
        pwd_q[31:0] <= pwdata;
      end
      if (wr_pwd_hi) begin
        pwd_q[63:32] <= pwdata;
      end
      if (wr_edge) begin
        edge_q <= pwdata[7:0];
      end
      if (wr_mask) begin
        mask_q <= pwdata[1:0];
      end
      if (wr_ridx) begin
        resp_idx_q <= pwdata[5:0];
      end
    end
  end

  // Edge detection on pin one only while designated for interrupts
  logic irq_sel;
  logic rise;
  logic fall;
  logic edge_evt;
  assign irq_sel = (pin_cfg_q[1].desig == GPFS_DES_IRQ);
  assign rise = pad_in[1] && !pin1_prev_q;
  assign fall = !pad_in[1] && pin1_prev_q;
  assign edge_evt = irq_sel && ((rise && edge_q[GPFS_BIT_EDGE_POS]) ||
                                (fall && edge_q[GPFS_BIT_EDGE_NEG]));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin1_prev_q <= 1'b0;
    end else begin
      pin1_prev_q <= pad_in[1];
    end
  end

  // Sticky status: a set in the clearing cycle wins
  logic [1:0] sts_set;
  logic [1:0] sts_clr;
  logic resp_evt;
  assign resp_evt = wr_go && !cmd_is_reset;
  assign sts_set = {resp_evt, edge_evt};
  assign sts_clr = wr_sts ? pwdata[1:0] : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_q <= GPFS_RST_STATUS;
    end else if (self_rst) begin
      sts_q <= GPFS_RST_STATUS;
    end else begin
      sts_q <= (sts_q & ~sts_clr) | sts_set;
    end
  end

  // Command outcome pulses; a reset command never answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_q <= 1'b0;
      chip_rst_q <= 1'b0;
    end else begin
      resp_q <= resp_evt;
      chip_rst_q <= self_rst;
    end
  end

  // Read mux, sampled in the setup cycle so data is ready in access
  logic [31:0] pins_word;
  logic [31:0] rd_mux;
  assign pins_word = {pin_byte(pin_cfg_q[3]), pin_byte(pin_cfg_q[2]),
                      pin_byte(pin_cfg_q[1]), pin_byte(pin_cfg_q[0])};

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_pin) begin
      rd_mux = {24'h00_0000, pin_byte(pin_cfg_q[pin_sel])};
    end else if (paddr == GPFS_OFS_PWD_LO) begin
      rd_mux = pwd_q[31:0];
    end else if (paddr == GPFS_OFS_PWD_HI) begin
      rd_mux = pwd_q[63:32];
    end else if (paddr == GPFS_OFS_EDGE) begin
      rd_mux = {24'h00_0000, edge_q};
    end else if (paddr == GPFS_OFS_STATUS) begin
      rd_mux = {30'h0000_0000, sts_q};
    end else if (paddr == GPFS_OFS_MASK) begin
      rd_mux = {30'h0000_0000, mask_q};
    end else if (paddr == GPFS_OFS_PIN_IN) begin
      rd_mux = {28'h000_0000, pad_in};
    end else if (paddr == GPFS_OFS_RESP_IDX) begin
      rd_mux = {26'h000_0000, resp_idx_q};
    end else if (paddr == GPFS_OFS_RESP_DATA) begin
      rd_mux = {24'h00_0000, resp_byte(resp_idx_q, pwd_q, pins_word)};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_q <= rd_mux;
    end
  end

  // Zero wait states; unmapped addresses answer with an error
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_known;
  assign resp_ready = resp_q;
  assign chip_reset_req = chip_rst_q;
  assign irq = |(sts_q & mask_q);

  // Function values per pin, in code order 001..100
  assign fn_drv[0] = {2'h0, serial_receive_indicator, suspend_indicator};
  assign fn_drv[1] = {1'b0, serial_transmit_indicator, 1'b0, clock_reference};
  assign fn_drv[2] = {3'h0, enumeration_done_indicator};
  assign fn_drv[3] = {3'h0, bus_activity_indicator};

  // One cell per pin, with its own function table
  for (genvar g = 0; g < GPFS_NUM_PINS; g++) begin : g_pin
    gpfs_pin_cell #(
      .FN_OUT(GPFS_FN_OUT[g]),
      .FN_ANA(GPFS_FN_ANA[g])
    ) u_cell (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(pin_cfg_q[g]),
      .fn_drv(fn_drv[g]),
      .pad(pad[g]),
      .analog_en(pin_analog[g])
    );
    assign pad_out[g] = pad[g].out;
    assign pad_oe_n[g] = pad[g].oe_n;
  end

  // Checks
  chk_gpio_out_value: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_cfg_q[0].desig == GPFS_DES_GPIO && !pin_cfg_q[0].dir_in) |=>
    (!pad_oe_n[0] && pad_out[0] == $past(pin_cfg_q[0].out_val)))
    else $error("gpio output value not driven");
  chk_gpio_dir_input: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_cfg_q[2].desig == GPFS_DES_GPIO && pin_cfg_q[2].dir_in) |=> pad_oe_n[2])
    else $error("gpio input pin is driven");
  chk_func_ignores_dir: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_cfg_q[0].desig == 3'h1) |=> (!pad_oe_n[0] && pad_out[0] == $past(suspend_indicator)))
    else $error("suspend function not routed");
  chk_pin1_analog: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_cfg_q[1].desig == 3'h2) |=> (pad_oe_n[1] && pin_analog[1]))
    else $error("analog input not selected");
  chk_pin2_enum: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_cfg_q[2].desig == 3'h1) |=> (pad_out[2] == $past(enumeration_done_indicator)))
    else $error("enumeration indicator not routed");
  chk_pin3_dac: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_cfg_q[3].desig == 3'h3) |=> (pin_analog[3] && pad_oe_n[3]))
    else $error("dac output not selected");
  chk_reset_no_resp: assert property (@(posedge pclk) disable iff (!presetn)
    self_rst |=> (chip_reset_req && !resp_ready) ##1 (pin_cfg_q[0] == GPFS_RST_PIN))
    else $error("reset command answered or no reset");
  chk_other_answered: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_go && !cmd_is_reset) |=> (resp_ready && sts_q[GPFS_STS_RESP] && !chip_reset_req))
    else $error("command not answered");
  chk_edge_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_evt && !self_rst) |=> sts_q[GPFS_STS_EDGE])
    else $error("edge flag not set");
  chk_spare_bits: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && hit_pin) |=> (prdata[31:5] == 27'h000_0000))
    else $error("spare bits read back");

  cov_reset_cmd: cover property (@(posedge pclk) disable iff (!presetn) self_rst);
  cov_edge_irq: cover property (@(posedge pclk) disable iff (!presetn) edge_evt ##1 irq);
  cov_resp: cover property (@(posedge pclk) disable iff (!presetn) resp_evt);

endmodule

//--- dv/gpfs_pad_model.sv
/*
  Pad environment of the four general pins: a weak pull-up on each pin
  and an external driver that the bench switches on and off.
  Assumes the block's drive enables are active low.
*/
module gpfs_pad_model (
  input wire logic [3:0] pad_out, // Block drive value
  input wire logic [3:0] pad_oe_n, // Block drive enable, low
  input wire logic [3:0] ext_val, // External driver value
  input wire logic [3:0] ext_en, // External driver on
  output logic [3:0] pad_in // Resolved pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Block wins, then the outside driver; a released pin rises to the pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pad_in[i] = !pad_oe_n[i] ? pad_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule

//--- dv/gp_pin_function_select_test.sv
/*
  Self-checking bench of the general pin function select block.
  Assumes zero-wait APB reads and registered pad and pulse outputs.
*/
module gp_pin_function_select_test import gpfs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, resp_ready, chip_reset_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [3:0] pad_in, pad_out, pad_oe_n, pin_analog, ext_val, ext_en;
  logic [5:0] src;
  logic [7:0] pcfg [4];
  logic [32:0] q [$];
  int fails = 0, num_checks = 0, n_resp = 0, n_rst = 0;

  gpfs_top gpfs_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pad_in, .pad_out, .pad_oe_n, .pin_analog,
    .suspend_indicator(src[0]), .serial_receive_indicator(src[1]),
    .serial_transmit_indicator(src[2]), .clock_reference(src[3]),
    .enumeration_done_indicator(src[4]), .bus_activity_indicator(src[5]),
    .resp_ready, .chip_reset_req, .irq);
  gpfs_pad_model gpfs_pad_model_i (.pad_out, .pad_oe_n, .ext_val, .ext_en, .pad_in);

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: pins/pulses %h, expected %h", $time, got, exp);
    end
  endtask

  task cmp_read(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; reads leave their expected {pslverr, prdata} in the queue
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      give_verdict();
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '0);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, '0, {1'b0, d});
  endtask

  task wpin(input int p, input logic [7:0] d);
    wr(GPFS_OFS_PIN0 + 8'(p * 4), d);
    pcfg[p] = d & 8'h1f;
  endtask

  // Pads are registered behind the settings register: two edges, then a quiet moment
  task settle();
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask

  // Whole command report: header bytes written last to first, one tail byte, then go
  task cmd(input logic [31:0] hdr, input logic [5:0] ti, input logic [7:0] tv, input bit rst);
    int r0, r1;
    r0 = n_resp;
    r1 = n_rst;
    for (int i = 3; i >= 0; i--) wr(GPFS_OFS_CMD_BYTE, {18'h0, 6'(i), hdr[31 - 8 * i -: 8]});
    wr(GPFS_OFS_CMD_BYTE, {18'h0, ti, tv});
    wr(GPFS_OFS_CMD_GO, 32'h0);
    settle(); // no wait for an answer beyond this
    check(32'(n_resp - r0), 32'(!rst));
    check(32'(n_rst - r1), 32'(rst));
  endtask

  // Expected {drives, value, analog} of pin p under designation c
  function logic [2:0] fexp(input int p, input int c);
    case ({2'(p), 3'(c)})
      {2'd0, 3'd1}: return {1'b1, src[0], 1'b0};
      {2'd0, 3'd2}: return {1'b1, src[1], 1'b0};
      {2'd1, 3'd1}: return {1'b1, src[3], 1'b0};
      {2'd1, 3'd3}: return {1'b1, src[2], 1'b0};
      {2'd2, 3'd1}: return {1'b1, src[4], 1'b0};
      {2'd3, 3'd1}: return {1'b1, src[5], 1'b0};
      {2'd1, 3'd2}, {2'd2, 3'd2}, {2'd2, 3'd3}, {2'd3, 3'd2}, {2'd3, 3'd3}: return 3'b001;
      default: return 3'b000;
    endcase
  endfunction

  // Watcher: pulse counts, and read results against the oldest note
  always @(posedge pclk) begin
    if (resp_ready === 1'b1) n_resp++;
    if (chip_reset_req === 1'b1) n_rst++;
    if (psel && penable && pready && !pwrite && q.size() > 0) begin
      cmp_read({pslverr, prdata}, q.pop_front());
    end
  end

  initial begin
    logic [31:0] v;
    logic [63:0] pw;
    logic [2:0] e;
    int p, c;
    seed = 32'hb817;
    {presetn, psel, penable, pwrite, paddr, pwdata, ext_val, ext_en, src} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check(32'(pad_oe_n), 32'hf);
    for (p = 0; p < 4; p++) rd(GPFS_OFS_PIN0 + 8'(p * 4), {24'h0, GPFS_RST_PIN});
    apb(1'b0, 8'h3c, '0, {1'b1, 32'h0}); // unmapped: error, zero data
    // Plain GPIO: output value, then input mode; upper bits written as ones
    for (p = 0; p < 4; p++) begin
      v = xs();
      wpin(p, {3'b111, v[0], 4'h0});
      settle();
      check(32'({pad_oe_n[p], pin_analog[p], pad_out[p]}), 32'(v[0]));
      rd(GPFS_OFS_PIN0 + 8'(p * 4), {27'h0, v[0], 4'h0});
      wpin(p, 8'h18);
      settle();
      check(32'({pad_oe_n[p], pin_analog[p], pad_out[p]}), 32'h4);
    end
    // Designations 001..111 of every pin, with GPIO bits set to be ignored
    for (p = 0; p < 4; p++) begin
      for (c = 1; c < 8; c++) begin
        @(posedge pclk);
        src <= 6'(xs());
        wpin(p, {5'h02, 3'(c)});
        settle();
        e = fexp(p, c);
        check(32'({pad_oe_n[p], pin_analog[p], e[2] & pad_out[p]}),
          32'({!e[2], e[0], e[1]}));
      end
      wpin(p, 8'h08);
    end
    // Response bytes: password, pin settings, ignored tail
    pw = {xs(), xs()};
    wr(GPFS_OFS_PWD_LO, pw[31:0]);
    wr(GPFS_OFS_PWD_HI, pw[63:32]);
    wpin(0, 8'hf2);
    for (c = 13; c < 28; c++) begin
      wr(GPFS_OFS_RESP_IDX, 32'(c));
      v = (c >= 14 && c <= 21) ? 32'(pw[(c - 14) * 8 +: 8]) :
        (c >= 22 && c <= 25) ? 32'(pcfg[c - 22]) : 32'h0;
      rd(GPFS_OFS_RESP_DATA, v);
    end
    // Edge detection on pin one: rising then falling, each polarity
    wpin(1, {5'h00, GPFS_DES_IRQ});
    ext_en <= 4'h2;
    wr(GPFS_OFS_MASK, 32'h3);
    for (c = 0; c < 4; c++) begin
      wr(GPFS_OFS_EDGE, c < 2 ? 32'h20 : 32'h40);
      wr(GPFS_OFS_STATUS, 32'h1);
      @(posedge pclk);
      ext_val <= {2'b0, ~c[0], 1'b0};
      settle();
      check(32'(irq), 32'(c == 0 || c == 3));
      rd(GPFS_OFS_STATUS, 32'(c == 0 || c == 3));
    end
    // Masked flag holds no interrupt; a one clears it
    wr(GPFS_OFS_MASK, 32'h2);
    settle();
    check(32'(irq), 32'h0);
    wr(GPFS_OFS_STATUS, 32'h1);
    rd(GPFS_OFS_STATUS, 32'h0);
    // Commands: spoiled signature, nonzero reserved byte, then a true reset
    cmd(32'h70abcdee, 6'd4, 8'h00, 1'b0);
    rd(GPFS_OFS_STATUS, 32'h2);
    @(negedge pclk);
    check(32'(irq), 32'h1);
    cmd(32'h70abcdef, 6'd63, 8'h01, 1'b0);
    // Settings were just changed, so the host follows with the reset command
    cmd(32'h70abcdef, 6'd40, 8'h00, 1'b1);
    rd(GPFS_OFS_PIN0, {24'h0, GPFS_RST_PIN});
    rd(GPFS_OFS_STATUS, 32'h0);
    rd(GPFS_OFS_EDGE, 32'h0);
    // All pins released: pull-ups, except pin one held low outside
    rd(GPFS_OFS_PIN_IN, 32'hd);
    @(negedge pclk);
    check(32'({irq, pad_oe_n}), 32'hf);
    repeat (2) @(posedge pclk);
    if (q.size() != 0) fails++;
    give_verdict();
  end
endmodule
